// *** system_power_control_regs.sv ***
`timescale 1ns/10ps

module system_power_control_regs #(
  parameter int unsigned ADDR_W = 20 // Peripheral bus address width
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire system_power_pkg::sys_event_t sys_events,
  input wire logic brownout_detector_low,
  input wire logic supply_above_1v8,
  output logic lowpower_mode_idle,
  output system_power_pkg::power_ctrl_t power_ctrl,
  output logic system_reset_n
);

  // Refuse address widths that cannot reach both registers
  if (ADDR_W < system_power_pkg::ADDR_BITS) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  // Merge masked data into one byte, keeping bits whose mask is clear
  function automatic logic [7:0] masked_byte(input logic [7:0] old_val, input logic [7:0] data,
                                             input logic [7:0] mask);
    masked_byte = (old_val & ~mask) | (data & mask);
  endfunction : masked_byte

  logic core_reset_flag_reg; // Core reset has happened
  logic lowpower_entry_flag_reg; // System has been in sleep or idle
  logic watchdog_flag_reg; // Watchdog reset or interrupt seen
  logic brownout_flag_reg; // Low-voltage reset seen
  logic brownout_start; // Pulse at the start of a brown-out hold
  logic sel_sys; // Address hits the system word
  logic sel_pwr; // Address hits the power word
  logic wr_en; // Access phase of a write
  logic setup_phase; // Setup phase of any access
  logic [7:0] low_mask; // Mask gating bits 7:0
  logic [7:0] high_mask; // Mask gating bits 23:16
  logic [7:0] sys_low_new; // System low byte after masking
  logic [7:0] sys_low_cur; // System low byte as it stands
  logic [7:0] pwr_low_new; // Power low byte after masking
  logic [7:0] pwr_high_new; // Power high byte after masking
  logic [7:0] pwr_low_cur; // Power low byte as it stands
  logic [7:0] pwr_high_cur; // Power high byte as it stands
  logic [31:0] prdata_next; // Read data for the coming access phase

  // Address decode and bus phases
  always_comb begin
    sel_sys = 1'b0;
    sel_pwr = 1'b0;
    if (paddr == ADDR_W'(system_power_pkg::SYS_STATUS_ADDR)) begin
      sel_sys = 1'b1;
    end else if (paddr == ADDR_W'(system_power_pkg::POWER_MGMT_ADDR)) begin
      sel_pwr = 1'b1;
    end
  end

  assign wr_en = psel && penable && pwrite && pready;
  assign setup_phase = psel && !penable;
  assign low_mask = pwdata[system_power_pkg::LOW_MASK_LSB +: 8];
  assign high_mask = pwdata[system_power_pkg::HIGH_MASK_LSB +: 8];

  // Current contents gathered into bytes
  assign sys_low_cur = {2'h0, core_reset_flag_reg, lowpower_mode_idle, lowpower_entry_flag_reg,
                        watchdog_flag_reg, 1'b0, brownout_flag_reg};
  assign pwr_high_cur = {4'h0, power_ctrl.analog_supply_voltage_sel, power_ctrl.analog_regulator_mode};
  assign pwr_low_cur = {3'h0, power_ctrl.bandgap_enable, power_ctrl.analog_ground_select,
                        power_ctrl.charge_pump_enable, power_ctrl.ref_out_buffer_enable,
                        power_ctrl.core_regulator_low_power};

  // Only mask-enabled bits take the written value
  assign sys_low_new = masked_byte(sys_low_cur, pwdata[7:0], low_mask);
  assign pwr_low_new = masked_byte(pwr_low_cur, pwdata[7:0], low_mask);
  assign pwr_high_new = masked_byte(pwr_high_cur, pwdata[system_power_pkg::HIGH_DATA_LSB +: 8],
                                    high_mask);

  // Brown-out reset hold and its start pulse
  brownout_reset_hold u_hold (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .brownout_detector_low(brownout_detector_low),
    .system_reset_n(system_reset_n),
    .brownout_start(brownout_start)
  );

  // Bus is always ready once out of reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // Read data and error captured in setup phase, shown in access phase
  always_comb begin
    prdata_next = system_power_pkg::WORD_ZERO;
    if (sel_sys) begin
      prdata_next[7:0] = sys_low_cur;
    end else if (sel_pwr) begin
      prdata_next[system_power_pkg::HIGH_DATA_LSB +: 8] = pwr_high_cur;
      prdata_next[7:0] = pwr_low_cur;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= system_power_pkg::WORD_ZERO;
    end else if (setup_phase) begin
      prdata <= prdata_next;
    end
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !(sel_sys || sel_pwr);
    end
  end

  // Sleep or idle select, fully software owned
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowpower_mode_idle <= system_power_pkg::BIT_RESET;
    end else if (wr_en && sel_sys) begin
      lowpower_mode_idle <= sys_low_new[system_power_pkg::SYS_IDLE_SEL_BIT];
    end
  end

  // Core reset flag: hardware sets, software writing zero clears, set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reset_flag_reg <= system_power_pkg::BIT_RESET;
    end else if (sys_events.core_reset_event) begin
      core_reset_flag_reg <= 1'b1;
    end else if (wr_en && sel_sys && !sys_low_new[system_power_pkg::SYS_CORE_RESET_BIT]) begin
      core_reset_flag_reg <= 1'b0;
    end
  end

  // Low-power entry flag: cleared by brown-out or reset circuit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowpower_entry_flag_reg <= system_power_pkg::BIT_RESET;
    end else if (sys_events.lowpower_entry_event) begin
      lowpower_entry_flag_reg <= 1'b1;
    end else if (brownout_start) begin
      lowpower_entry_flag_reg <= 1'b0;
    end else if (wr_en && sel_sys && !sys_low_new[system_power_pkg::SYS_LOWPOWER_FLAG_BIT]) begin
      lowpower_entry_flag_reg <= 1'b0;
    end
  end

  // Watchdog flag: cleared by brown-out or external reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_flag_reg <= system_power_pkg::BIT_RESET;
    end else if (sys_events.watchdog_event) begin
      watchdog_flag_reg <= 1'b1;
    end else if (brownout_start || sys_events.ext_reset_event) begin
      watchdog_flag_reg <= 1'b0;
    end else if (wr_en && sel_sys && !sys_low_new[system_power_pkg::SYS_WATCHDOG_FLAG_BIT]) begin
      watchdog_flag_reg <= 1'b0;
    end
  end

  // Brown-out flag: set by low supply, self-clears once above 1.8V
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      brownout_flag_reg <= system_power_pkg::BROWNOUT_FLAG_RESET;
    end else if (brownout_detector_low) begin
      brownout_flag_reg <= 1'b1;
    end else if (supply_above_1v8) begin
      brownout_flag_reg <= 1'b0;
    end else if (wr_en && sel_sys && !sys_low_new[system_power_pkg::SYS_BROWNOUT_FLAG_BIT]) begin
      brownout_flag_reg <= 1'b0;
    end
  end

  // Analog-supply regulator fields from the power high byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_ctrl.analog_supply_voltage_sel <= system_power_pkg::FIELD2_RESET;
      power_ctrl.analog_regulator_mode <= system_power_pkg::FIELD2_RESET;
    end else if (wr_en && sel_pwr) begin
      // Voltage code 2.4/2.7/3.0/3.3V
      power_ctrl.analog_supply_voltage_sel <=
        pwr_high_new[system_power_pkg::PWR_VSEL_LSB - system_power_pkg::HIGH_DATA_LSB +: 2];
      // High-Z, short to main supply, pull-down, regulate
      power_ctrl.analog_regulator_mode <=
        pwr_high_new[system_power_pkg::PWR_MODE_LSB - system_power_pkg::HIGH_DATA_LSB +: 2];
    end
  end

  // Analog enables and selects from the power low byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_ctrl.bandgap_enable <= system_power_pkg::BIT_RESET;
      power_ctrl.analog_ground_select <= system_power_pkg::BIT_RESET;
      power_ctrl.charge_pump_enable <= system_power_pkg::BIT_RESET;
      power_ctrl.ref_out_buffer_enable <= system_power_pkg::BIT_RESET;
      power_ctrl.core_regulator_low_power <= system_power_pkg::BIT_RESET;
    end else if (wr_en && sel_pwr) begin
      power_ctrl.bandgap_enable <= pwr_low_new[system_power_pkg::PWR_BANDGAP_BIT];
      power_ctrl.analog_ground_select <= pwr_low_new[system_power_pkg::PWR_GND_SEL_BIT];
      power_ctrl.charge_pump_enable <= pwr_low_new[system_power_pkg::PWR_CHARGE_PUMP_BIT];
      power_ctrl.ref_out_buffer_enable <= pwr_low_new[system_power_pkg::PWR_REF_BUF_BIT];
      // Software drives this around standby entry and wake-up
      power_ctrl.core_regulator_low_power <= pwr_low_new[system_power_pkg::PWR_CORE_LP_BIT];
    end
  end

endmodule : system_power_control_regs

// *** system_power_pkg.sv ***
package system_power_pkg;

  // Register byte addresses on the peripheral bus
  localparam int unsigned ADDR_BITS = 20;
  localparam logic [19:0] SYS_STATUS_ADDR = 20'h40104;
  localparam logic [19:0] POWER_MGMT_ADDR = 20'h40400;

  // Mask byte positions: the upper byte of each half gates the lower byte
  localparam int unsigned LOW_MASK_LSB = 8;
  localparam int unsigned HIGH_MASK_LSB = 24;
  localparam int unsigned HIGH_DATA_LSB = 16;

  // System word field positions
  localparam int unsigned SYS_CORE_RESET_BIT = 5;
  localparam int unsigned SYS_IDLE_SEL_BIT = 4;
  localparam int unsigned SYS_LOWPOWER_FLAG_BIT = 3;
  localparam int unsigned SYS_WATCHDOG_FLAG_BIT = 2;
  localparam int unsigned SYS_BROWNOUT_FLAG_BIT = 0;

  // Power word field positions
  localparam int unsigned PWR_VSEL_LSB = 18;
  localparam int unsigned PWR_MODE_LSB = 16;
  localparam int unsigned PWR_BANDGAP_BIT = 4;
  localparam int unsigned PWR_GND_SEL_BIT = 3;
  localparam int unsigned PWR_CHARGE_PUMP_BIT = 2;
  localparam int unsigned PWR_REF_BUF_BIT = 1;
  localparam int unsigned PWR_CORE_LP_BIT = 0;

  // Reset values
  localparam logic BROWNOUT_FLAG_RESET = 1'b1;
  localparam logic [1:0] FIELD2_RESET = 2'h0;
  localparam logic BIT_RESET = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Regulator voltage select codes
  localparam logic [1:0] VSEL_2V4 = 2'h0;
  localparam logic [1:0] VSEL_2V7 = 2'h1;
  localparam logic [1:0] VSEL_3V0 = 2'h2;
  localparam logic [1:0] VSEL_3V3 = 2'h3;

  // Analog-supply regulator mode codes
  localparam logic [1:0] REG_MODE_HIGH_Z = 2'h0;
  localparam logic [1:0] REG_MODE_SHORT_MAIN = 2'h1;
  localparam logic [1:0] REG_MODE_PULL_DOWN = 2'h2;
  localparam logic [1:0] REG_MODE_REGULATE = 2'h3;

  // Outputs that steer the analog power circuits
  typedef struct packed {
    logic [1:0] analog_supply_voltage_sel;
    logic [1:0] analog_regulator_mode;
    logic bandgap_enable;
    logic analog_ground_select;
    logic charge_pump_enable;
    logic ref_out_buffer_enable;
    logic core_regulator_low_power;
  } power_ctrl_t;

  // One-cycle event pulses from the rest of the chip
  typedef struct packed {
    logic core_reset_event;
    logic lowpower_entry_event;
    logic watchdog_event;
    logic ext_reset_event;
  } sys_event_t;

  // Reset hold sequencer states
  typedef enum logic [1:0] {
    HOLD_RUN = 2'b01,
    HOLD_BROWNOUT = 2'b10
  } hold_state_t;

endpackage : system_power_pkg

// *** brownout_reset_hold.sv ***
`timescale 1ns/10ps

// Holds the system in reset while the detector reports low supply
module brownout_reset_hold (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic brownout_detector_low,
  output logic system_reset_n,
  output logic brownout_start
);

  system_power_pkg::hold_state_t state_reg; // Sequencer state
  system_power_pkg::hold_state_t state_next; // Next sequencer state

  // Next state: enter hold on low supply, leave once supply recovers
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      system_power_pkg::HOLD_RUN: begin
        if (brownout_detector_low) begin
          state_next = system_power_pkg::HOLD_BROWNOUT;
        end
      end
      system_power_pkg::HOLD_BROWNOUT: begin
        if (!brownout_detector_low) begin
          state_next = system_power_pkg::HOLD_RUN;
        end
      end
      default: begin
        state_next = system_power_pkg::HOLD_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= system_power_pkg::HOLD_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset output stays low for the whole brown-out hold
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      system_reset_n <= 1'b0;
    end else begin
      system_reset_n <= (state_next == system_power_pkg::HOLD_RUN);
    end
  end

  // One-cycle pulse when a brown-out hold begins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      brownout_start <= 1'b0;
    end else begin
      brownout_start <= (state_reg == system_power_pkg::HOLD_RUN) && brownout_detector_low;
    end
  end

endmodule : brownout_reset_hold

// *** system_power_control_regs_sva.sv ***
`timescale 1ns/10ps

// Watches the register bank ports for mask, field and brown-out behaviour
module system_power_control_regs_chk #(
  parameter int unsigned ADDR_W = 20 // Bus address width
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire system_power_pkg::sys_event_t sys_events,
  input wire logic brownout_detector_low,
  input wire logic supply_above_1v8,
  input wire logic lowpower_mode_idle,
  input wire system_power_pkg::power_ctrl_t power_ctrl,
  input wire logic system_reset_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Completed writes and read setups of each word
  sequence sys_wr;
    psel && penable && pwrite && pready && paddr == system_power_pkg::SYS_STATUS_ADDR;
  endsequence
  sequence pwr_wr;
    psel && penable && pwrite && pready && paddr == system_power_pkg::POWER_MGMT_ADDR;
  endsequence
  sequence sys_rd;
    psel && !penable && !pwrite && paddr == system_power_pkg::SYS_STATUS_ADDR;
  endsequence
  sequence pwr_rd;
    psel && !penable && !pwrite && paddr == system_power_pkg::POWER_MGMT_ADDR;
  endsequence
  // Watchdog event, no clearing cause in the next cycle, then a read setup
  sequence wd_set_then_rd;
    (sys_events.watchdog_event && !brownout_detector_low)
      ##1 (!(psel && penable) && !sys_events.ext_reset_event) ##1 sys_rd;
  endsequence
  // Supply good with the detector quiet, then a read setup
  sequence supply_ok_then_rd;
    (supply_above_1v8 && !brownout_detector_low) ##1 !brownout_detector_low ##0 sys_rd;
  endsequence

  a_idle_write: assert property ((sys_wr ##0 pwdata[12]) |=> lowpower_mode_idle == $past(pwdata[4]))
    else $error("idle select did not follow a masked write");
  a_idle_keep: assert property ((sys_wr ##0 !pwdata[12]) |=> $stable(lowpower_mode_idle))
    else $error("idle select changed without its mask bit");
  a_vsel_write: assert property ((pwr_wr ##0 pwdata[27:26] == 2'h3)
    |=> power_ctrl.analog_supply_voltage_sel == $past(pwdata[19:18]))
    else $error("voltage select did not follow a masked write");
  a_mode_write: assert property ((pwr_wr ##0 pwdata[25:24] == 2'h3)
    |=> power_ctrl.analog_regulator_mode == $past(pwdata[17:16]))
    else $error("regulator mode did not follow a masked write");
  a_enables_write: assert property ((pwr_wr ##0 pwdata[12:8] == 5'h1f)
    |=> power_ctrl[4:0] == $past(pwdata[4:0]))
    else $error("enable bits did not follow a masked write");
  a_bo_hold: assert property (brownout_detector_low |=> !system_reset_n)
    else $error("system reset not held during low supply");
  a_bo_release: assert property (!brownout_detector_low |=> system_reset_n)
    else $error("system reset held with supply good");
  a_unmapped_err: assert property ((psel && !penable && paddr != system_power_pkg::SYS_STATUS_ADDR
    && paddr != system_power_pkg::POWER_MGMT_ADDR) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_sys_read: assert property (sys_rd |=> prdata[4] == lowpower_mode_idle && prdata[31:6] == 26'h0
    && !prdata[1] && !pslverr)
    else $error("system word read wrong");
  a_pwr_read: assert property (pwr_rd |=> prdata[19:16] == power_ctrl[8:5] && prdata[4:0] == power_ctrl[4:0]
    && (prdata & 32'hfff0_ffe0) == 32'h0)
    else $error("power word read wrong");
  a_wd_seen: assert property (wd_set_then_rd |=> prdata[2])
    else $error("watchdog flag not seen after its event");
  a_bo_selfclear: assert property (supply_ok_then_rd |=> !prdata[0])
    else $error("brown-out flag did not clear with supply good");
endmodule : system_power_control_regs_chk

bind system_power_control_regs system_power_control_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sys_events(sys_events), .brownout_detector_low(brownout_detector_low),
  .supply_above_1v8(supply_above_1v8), .lowpower_mode_idle(lowpower_mode_idle),
  .power_ctrl(power_ctrl), .system_reset_n(system_reset_n));

// *** test_system_power_control_regs.sv ***
`timescale 1ns/10ps

// Self-checking bench with an integer model of both words
module test_system_power_control_regs;
  localparam logic [19:0] sys_a = system_power_pkg::SYS_STATUS_ADDR; // System word
  localparam logic [19:0] pwr_a = system_power_pkg::POWER_MGMT_ADDR; // Power word
  localparam logic [19:0] bad_a = 20'h40108; // Unmapped address
  logic sys_clk, reset_n, psel, penable, pwrite, brownout_detector_low, supply_above_1v8;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, r, d;
  logic pready, pslverr, err_q, lowpower_mode_idle, system_reset_n;
  system_power_pkg::sys_event_t sys_events;
  system_power_pkg::power_ctrl_t power_ctrl;
  int sys_m, pwr_m, fails, checks_done, seed; // Model words and counters

  system_power_control_regs u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_events(sys_events), .brownout_detector_low(brownout_detector_low),
    .supply_above_1v8(supply_above_1v8), .lowpower_mode_idle(lowpower_mode_idle),
    .power_ctrl(power_ctrl), .system_reset_n(system_reset_n));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Prints the verdict and stops
  task automatic end_sim();
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // One comparison against the model
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  // One bus transfer: setup, access, held until ready is seen
  task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] dat);
    int n;
    @(negedge sys_clk);
    psel = 1'b1; pwrite = w; paddr = a; pwdata = dat; penable = 1'b0;
    @(negedge sys_clk);
    penable = 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end else begin
      rd_q = prdata;
      err_q = pslverr;
      @(negedge sys_clk);
      psel = 1'b0; penable = 1'b0;
    end
  endtask : acc

  // Transfer, model update and comparison of read data and outputs
  task automatic step(input logic w, input logic [19:0] a, input logic [31:0] dat);
    logic [31:0] m;
    acc(w, a, dat);
    chk("pslverr", 32'(a != sys_a && a != pwr_a), 32'(err_q));
    if (!w) chk("prdata", a == sys_a ? sys_m & 32'h3d : a == pwr_a ? pwr_m & 32'h000f_001f : 0, rd_q);
    else if (a == sys_a) begin
      // Idle select follows its mask; flags only clear on masked zero
      if (dat[12]) sys_m[4] = dat[4];
      sys_m = sys_m & ~(dat[15:8] & ~dat[7:0] & 8'h2d);
    end else if (a == pwr_a) begin
      m = {8'h00, dat[31:24], 8'h00, dat[15:8]} & 32'h000f_001f;
      pwr_m = (pwr_m & ~m) | (dat & m);
    end
    chk("lowpower_mode_idle", 32'(sys_m[4]), 32'(lowpower_mode_idle));
    chk("power_ctrl", {pwr_m[19:16], pwr_m[4:0]}, 32'(power_ctrl));
  endtask : step

  // One-cycle event pulse, mirrored in the model
  task automatic pulse(input logic [3:0] ev);
    @(negedge sys_clk);
    sys_events = system_power_pkg::sys_event_t'(ev);
    @(negedge sys_clk);
    sys_events = '0;
    if (ev[3]) sys_m[5] = 1'b1;
    if (ev[2]) sys_m[3] = 1'b1;
    if (ev[1]) sys_m[2] = 1'b1;
    if (ev[0]) sys_m[2] = 1'b0;
  endtask : pulse

  // Main sequence
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; sys_events = '0;
    brownout_detector_low = 1'b0; supply_above_1v8 = 1'b0; reset_n = 1'b0;
    sys_m = 32'h1; pwr_m = 0; fails = 0; checks_done = 0; seed = 86;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    step(1'b0, sys_a, 32'h0);
    step(1'b0, pwr_a, 32'h0);
    step(1'b1, bad_a, 32'hffff_ffff);
    step(1'b0, bad_a, 32'h0);
    for (int i = 0; i < 4; i++) begin
      step(1'b1, pwr_a, {8'h0f, 4'h0, i[1:0], i[1:0], 8'h1f, 8'(i * 7)});
    end
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      d = $random(seed);
      step(r[0], r[2:1] == 2'h3 ? bad_a : r[1] ? pwr_a : sys_a, d);
    end
    pulse(4'b1000);
    pulse(4'b0100);
    pulse(4'b0010);
    step(1'b0, sys_a, 32'h0);
    step(1'b1, sys_a, 32'h0000_3000);
    pulse(4'b0001);
    step(1'b0, sys_a, 32'h0);
    // Bandgap first, then buffer and core low power before standby
    step(1'b1, pwr_a, 32'h0000_1010);
    step(1'b1, pwr_a, 32'h0000_0303);
    pulse(4'b0100);
    // Core regulator back to normal after wake-up
    step(1'b1, pwr_a, 32'h0000_0100);
    pulse(4'b0110);
    // Low supply: reset held, entry and watchdog flags cleared
    @(negedge sys_clk);
    brownout_detector_low = 1'b1;
    @(negedge sys_clk);
    chk("system_reset_n", 32'h0, 32'(system_reset_n));
    repeat (3) @(negedge sys_clk);
    brownout_detector_low = 1'b0;
    sys_m = (sys_m & ~32'hc) | 32'h1;
    @(negedge sys_clk);
    chk("system_reset_n", 32'h1, 32'(system_reset_n));
    step(1'b0, sys_a, 32'h0);
    supply_above_1v8 = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_m[0] = 1'b0;
    step(1'b0, sys_a, 32'h0);
    // Mid-run reset: fields back to zero, brown-out flag back to one
    @(negedge sys_clk);
    reset_n = 1'b0;
    supply_above_1v8 = 1'b0;
    sys_m = 32'h1;
    pwr_m = 0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    step(1'b0, sys_a, 32'h0);
    step(1'b0, pwr_a, 32'h0);
    end_sim();
  end
endmodule : test_system_power_control_regs
